// ===== core/pief_flag_bank.sv
// Sticky flag bank: hardware sets, software writes, set beats a same-cycle clear
`timescale 1ns/100ps
module pief_flag_bank
	import pief_pkg::*;
#(
	parameter int         W    = REG_W,
	parameter logic [7:0] MASK = IMPL_MASK
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] set_i,
	input  wire logic         wr_i,
	input  wire logic [W-1:0] wr_data_i,
	output logic      [W-1:0] flags_o
);
	typedef struct packed {
		logic [W-1:0] flags;
	} pief_bank_t;

	pief_bank_t st_r;
	pief_bank_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (wr_i) begin
			st_nxt.flags = wr_data_i;
		end
		// An event in the clearing cycle must not be lost
		st_nxt.flags = (st_nxt.flags | set_i) & MASK[W-1:0];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r.flags <= REG_RESET[W-1:0];
		end else begin
			st_r <= st_nxt;
		end
	end

	assign flags_o = st_r.flags;
endmodule : pief_flag_bank

// ===== core/pief_pkg.sv
// Package: register map, bit positions and modes of the peripheral interrupt flag block
package pief_pkg;
	localparam int          ADDR_W       = 8;
	localparam int          DATA_W       = 32;
	localparam int          REG_W        = 8;
	localparam logic [7:0]  FLAGS_OFF    = 8'h0C;
	localparam logic [7:0]  ENABLES_OFF  = 8'h8C;
	localparam logic [7:0]  CTRL_OFF     = 8'h10;
	localparam logic [7:0]  PEND_OFF     = 8'h14;
	localparam int          BIT_T1       = 0;
	localparam int          BIT_T2       = 1;
	localparam int          BIT_CC       = 2;
	localparam int          BIT_SP       = 3;
	localparam int          BIT_CV       = 6;
	localparam int          CTRL_MODE_LO = 0;
	localparam int          CTRL_MODE_HI = 1;
	localparam int          CTRL_PERIPH_MASTER_IRQ_EN    = 6;
	localparam int          CTRL_GIE     = 7;
	localparam logic [7:0]  IMPL_MASK    = 8'h4F;
	localparam logic [7:0]  NOCONV_MASK  = 8'h0F;
	localparam logic [7:0]  REG_RESET    = 8'h00;
	localparam logic [7:0]  CTRL_MASK    = 8'hC3;
	localparam logic [23:0] DAT_PAD      = 24'h000000;

	typedef enum logic [1:0] {
		PIEF_CC_OFF  = 2'b00,
		PIEF_CC_CAPT = 2'b01,
		PIEF_CC_CMP  = 2'b10,
		PIEF_CC_PWM  = 2'b11
	} pief_ccmode_t;
endpackage : pief_pkg

// ===== core/pief_top.sv
// Peripheral interrupt flags and enables behind a classic Wishbone slave
// Operation
// - Byte enable register: bit0 timer1, bit1 timer2, bit2 capcmp, bit3 serial, bit6 conv.
// - Bits 7, 5 and 4 of flags and enables read zero; writes ignored.
// - No peripheral request reaches the core unless the master enable is set.
// - Flags set on their event regardless of own enable or global enable.
// - Byte flag register; flags stay set until software writes zero.
// - Conversion flag bit 6 sets on conversion done, zero when none pending.
// - Serial flag bit 3 sets on transfer done; zero means still waiting.
// - Capcmp flag bit 2 sets on capture in capture mode or compare match in compare mode; unused when off or in PWM.
// - Timer2 period match sets bit 1; its enable gates it into the request.
// - Timer1 overflow sets bit 0; its enable gates it into the request.
// - Reset clears every implemented enable and flag; all implemented bits read/write.
`timescale 1ns/100ps
module pief_top
	import pief_pkg::*;
#(
	parameter bit HAS_CONV = 1'b1
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [ADDR_W-1:0] wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [DATA_W-1:0] wb_dat_i,
	output logic      [DATA_W-1:0] wb_dat_o,
	output logic                   wb_ack_o,
	input  wire logic              timer1_overflow_i,
	input  wire logic              timer2_match_i,
	input  wire logic              capture_evt_i,
	input  wire logic              compare_evt_i,
	input  wire logic              serial_done_i,
	input  wire logic              conv_done_i,
	output logic                   periph_irq_o
);
	// Without a converter bit 6 is held at zero as well
	localparam logic [7:0] MASK = HAS_CONV ? IMPL_MASK : NOCONV_MASK;

	typedef struct packed {
		logic               ack;
		logic [REG_W-1:0]   rdat;
		logic [REG_W-1:0]   en;
		logic               periph_master_irq_en;
		logic               global_irq_en;
		pief_ccmode_t       mode;
		logic               irq;
	} pief_state_t;

	pief_state_t      st_r;
	pief_state_t      st_nxt;
	logic [REG_W-1:0] flags_w;
	logic [REG_W-1:0] set_w;
	logic             req_w;
	logic             wr_go;
	logic             fl_wr;
	logic             en_wr;
	logic             ctl_wr;
	logic             capcmp_evt;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	function automatic logic [REG_W-1:0] pend(input logic [REG_W-1:0] f,
		input logic [REG_W-1:0] e);
		pend = f & e;
	endfunction : pend

	assign req_w = wb_cyc_i & wb_stb_i;
	// Writes land on the edge at which the master samples ack
	assign wr_go  = req_w & wb_we_i & st_r.ack & wb_sel_i[0];
	assign fl_wr  = wr_go & hit(wb_adr_i, FLAGS_OFF);
	assign en_wr  = wr_go & hit(wb_adr_i, ENABLES_OFF);
	assign ctl_wr = wr_go & hit(wb_adr_i, CTRL_OFF);

	// Capture and compare share one flag; PWM leaves it untouched
	always_comb begin
		case (st_r.mode)
			PIEF_CC_CAPT: capcmp_evt = capture_evt_i;
			PIEF_CC_CMP:  capcmp_evt = compare_evt_i;
			PIEF_CC_OFF:  capcmp_evt = 1'b0;
			PIEF_CC_PWM:  capcmp_evt = 1'b0;
			default:      capcmp_evt = 1'b0;
		endcase
	end

	// Sources set flags whatever the enables say
	always_comb begin
		set_w         = REG_RESET;
		set_w[BIT_T1] = timer1_overflow_i;
		set_w[BIT_T2] = timer2_match_i;
		set_w[BIT_CC] = capcmp_evt;
		set_w[BIT_SP] = serial_done_i;
		set_w[BIT_CV] = conv_done_i & HAS_CONV;
	end

	pief_flag_bank #(
		.W    (REG_W),
		.MASK (MASK)
	) u_flags (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.set_i     (set_w),
		.wr_i      (fl_wr),
		.wr_data_i (wb_dat_i[REG_W-1:0]),
		.flags_o   (flags_w)
	);

	always_comb begin
		st_nxt     = st_r;
		st_nxt.ack = req_w & ~st_r.ack;
		st_nxt.rdat = REG_RESET;
		if (req_w & ~st_r.ack) begin
			if (hit(wb_adr_i, FLAGS_OFF)) begin
				st_nxt.rdat = flags_w & MASK;
			end else if (hit(wb_adr_i, ENABLES_OFF)) begin
				st_nxt.rdat = st_r.en & MASK;
			end else if (hit(wb_adr_i, CTRL_OFF)) begin
				st_nxt.rdat[CTRL_GIE]                  = st_r.global_irq_en;
				st_nxt.rdat[CTRL_PERIPH_MASTER_IRQ_EN]                 = st_r.periph_master_irq_en;
				st_nxt.rdat[CTRL_MODE_HI:CTRL_MODE_LO] = st_r.mode;
			end else if (hit(wb_adr_i, PEND_OFF)) begin
				st_nxt.rdat = pend(flags_w, st_r.en);
			end
		end
		if (en_wr) begin
			st_nxt.en = wb_dat_i[REG_W-1:0] & MASK;
		end
		if (ctl_wr) begin
			st_nxt.global_irq_en  = wb_dat_i[CTRL_GIE];
			st_nxt.periph_master_irq_en = wb_dat_i[CTRL_PERIPH_MASTER_IRQ_EN];
			st_nxt.mode = pief_ccmode_t'(wb_dat_i[CTRL_MODE_HI:CTRL_MODE_LO]);
		end
		// One cycle of latency keeps the request output straight off a flop
		st_nxt.irq = (|pend(flags_w, st_r.en)) & st_r.periph_master_irq_en & st_r.global_irq_en;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r.ack  <= 1'b0;
			st_r.rdat <= REG_RESET;
			st_r.en   <= REG_RESET;
			st_r.periph_master_irq_en <= 1'b0;
			st_r.global_irq_en  <= 1'b0;
			st_r.mode <= PIEF_CC_OFF;
			st_r.irq  <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign wb_dat_o     = {DAT_PAD, st_r.rdat};
	assign wb_ack_o     = st_r.ack;
	assign periph_irq_o = st_r.irq;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	enables_wr_a: assert property (
		en_wr |=> (st_r.en == ($past(wb_dat_i[REG_W-1:0]) & MASK)))
		else $error("enable write not stored");

	unimpl_zero_a: assert property (
		wb_ack_o && (hit(wb_adr_i, FLAGS_OFF) || hit(wb_adr_i, ENABLES_OFF))
		|-> ((wb_dat_o[REG_W-1:0] & ~IMPL_MASK) == REG_RESET))
		else $error("unimplemented bit read nonzero");

	master_gate_a: assert property (
		!st_r.periph_master_irq_en |=> !periph_irq_o)
		else $error("request without master enable");

	flag_set_a: assert property (
		timer1_overflow_i |=> flags_w[BIT_T1])
		else $error("timer1 flag not set");

	flag_hold_a: assert property (
		!fl_wr |=> ((flags_w & $past(flags_w)) == $past(flags_w)))
		else $error("flag cleared without software write");

	conv_set_a: assert property (
		conv_done_i && HAS_CONV |=> flags_w[BIT_CV])
		else $error("conversion flag not set");

	serial_set_a: assert property (
		serial_done_i |=> flags_w[BIT_SP])
		else $error("serial flag not set");

	capcmp_pwm_a: assert property (
		st_r.mode == PIEF_CC_PWM && !fl_wr && !flags_w[BIT_CC] |=> !flags_w[BIT_CC])
		else $error("capcmp flag set in pwm mode");

	timer2_req_a: assert property (
		timer2_match_i && st_r.en[BIT_T2] && st_r.periph_master_irq_en && st_r.global_irq_en && !wr_go
		|-> ##2 periph_irq_o)
		else $error("timer2 match did not raise request");

	reset_clear_a: assert property (
		@(posedge clk_i) disable iff (1'b0)
		$fell(rst_i) |-> (st_r.en == REG_RESET && flags_w == REG_RESET && !periph_irq_o))
		else $error("state not cleared by reset");

	irq_formula_a: assert property (
		!$past(rst_i) |-> (periph_irq_o ==
		((|$past(flags_w & st_r.en)) && $past(st_r.periph_master_irq_en) && $past(st_r.global_irq_en))))
		else $error("request does not match flags and enables");

	// Bus answer: one ack per request, one cycle after it is taken
	ack_pulse_a: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	ack_answer_a: assert property (
		req_w && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered in the next cycle");

	ack_idle_a: assert property (
		!req_w |=> !wb_ack_o)
		else $error("ack without a request");

	dat_idle_a: assert property (
		!wb_ack_o |-> (wb_dat_o == {DAT_PAD, REG_RESET}))
		else $error("read data not zero outside ack");

	flags_rd_a: assert property (
		req_w && !wb_ack_o && hit(wb_adr_i, FLAGS_OFF)
		|=> (wb_dat_o[REG_W-1:0] == ($past(flags_w) & MASK)))
		else $error("flag read does not match stored flags");

	enables_rd_a: assert property (
		req_w && !wb_ack_o && hit(wb_adr_i, ENABLES_OFF)
		|=> (wb_dat_o[REG_W-1:0] == $past(st_r.en)))
		else $error("enable read does not match stored enables");

	pend_rd_a: assert property (
		req_w && !wb_ack_o && hit(wb_adr_i, PEND_OFF)
		|=> (wb_dat_o[REG_W-1:0] == ($past(flags_w) & $past(st_r.en))))
		else $error("pending read does not match flags and enables");

	ctrl_rd_a: assert property (
		req_w && !wb_ack_o && hit(wb_adr_i, CTRL_OFF)
		|=> (wb_dat_o[CTRL_PERIPH_MASTER_IRQ_EN] == $past(st_r.periph_master_irq_en)
		&& wb_dat_o[CTRL_GIE] == $past(st_r.global_irq_en)))
		else $error("control read does not match stored enables");

	// Only software writes move enables and control
	en_hold_a: assert property (
		!en_wr |=> (st_r.en == $past(st_r.en)))
		else $error("enables changed without a write");

	ctrl_hold_a: assert property (
		!ctl_wr |=> (st_r.periph_master_irq_en == $past(st_r.periph_master_irq_en) && st_r.global_irq_en == $past(st_r.global_irq_en)
		&& st_r.mode == $past(st_r.mode)))
		else $error("control changed without a write");

	unimpl_state_a: assert property (
		((flags_w & ~MASK) == REG_RESET) && ((st_r.en & ~MASK) == REG_RESET))
		else $error("unimplemented bit holds a one");

	nocnv_flag_a: assert property (
		!HAS_CONV |-> !flags_w[BIT_CV])
		else $error("conversion flag set without a converter");

	unmapped_wr_a: assert property (
		wr_go && !fl_wr && !en_wr && !ctl_wr && !(|set_w)
		|=> (flags_w == $past(flags_w) && st_r.en == $past(st_r.en)))
		else $error("write to no register changed state");

	// Flag bank: writes store, events set, an event beats a clear
	flag_write_a: assert property (
		fl_wr && !(|set_w) |=> (flags_w == ($past(wb_dat_i[REG_W-1:0]) & MASK)))
		else $error("flag write not stored");

	set_wins_a: assert property (
		fl_wr && (|set_w) |=> ((flags_w & $past(set_w)) == $past(set_w)))
		else $error("event lost against a software clear");

	timer2_set_a: assert property (
		timer2_match_i |=> flags_w[BIT_T2])
		else $error("timer2 flag not set");

	capture_set_a: assert property (
		st_r.mode == PIEF_CC_CAPT && capture_evt_i |=> flags_w[BIT_CC])
		else $error("capture did not set capcmp flag");

	compare_set_a: assert property (
		st_r.mode == PIEF_CC_CMP && compare_evt_i |=> flags_w[BIT_CC])
		else $error("compare match did not set capcmp flag");

	capcmp_off_a: assert property (
		st_r.mode == PIEF_CC_OFF && !fl_wr && !flags_w[BIT_CC] |=> !flags_w[BIT_CC])
		else $error("capcmp flag set with unit off");

	// Request path: an enabled source reaches the core two cycles after its event once master and global enables are set
	global_gate_a: assert property (
		!st_r.global_irq_en |=> !periph_irq_o)
		else $error("request without global enable");

	irq_drop_a: assert property (
		!(|pend(flags_w, st_r.en)) |=> !periph_irq_o)
		else $error("request without a pending source");

	timer1_req_a: assert property (
		timer1_overflow_i && st_r.en[BIT_T1] && st_r.periph_master_irq_en && st_r.global_irq_en && !wr_go
		|-> ##2 periph_irq_o)
		else $error("timer1 overflow did not raise request");

	serial_req_a: assert property (
		serial_done_i && st_r.en[BIT_SP] && st_r.periph_master_irq_en && st_r.global_irq_en && !wr_go
		|-> ##2 periph_irq_o)
		else $error("serial transfer did not raise request");

	capcmp_req_a: assert property (
		capcmp_evt && st_r.en[BIT_CC] && st_r.periph_master_irq_en && st_r.global_irq_en && !wr_go
		|-> ##2 periph_irq_o)
		else $error("capcmp event did not raise request");

	conv_req_a: assert property (
		conv_done_i && HAS_CONV && st_r.en[BIT_CV] && st_r.periph_master_irq_en && st_r.global_irq_en && !wr_go
		|-> ##2 periph_irq_o)
		else $error("conversion did not raise request");

	// Reset leaves bus and control quiet
	reset_ctrl_a: assert property (
		@(posedge clk_i) disable iff (1'b0)
		$fell(rst_i) |-> (!st_r.periph_master_irq_en && !st_r.global_irq_en && st_r.mode == PIEF_CC_OFF))
		else $error("control not cleared by reset");

	reset_bus_a: assert property (
		@(posedge clk_i) disable iff (1'b0)
		$fell(rst_i) |-> (!wb_ack_o && wb_dat_o == {DAT_PAD, REG_RESET}))
		else $error("bus outputs not quiet after reset");

	enable_write_c: cover property (en_wr ##1 st_r.en != REG_RESET);
	irq_rise_c:     cover property ($rose(periph_irq_o));
	capture_set_c:  cover property (st_r.mode == PIEF_CC_CAPT && capture_evt_i
		##1 flags_w[BIT_CC]);
	set_clear_c:    cover property (fl_wr && serial_done_i);
	compare_set_c:  cover property (st_r.mode == PIEF_CC_CMP && compare_evt_i
		##1 flags_w[BIT_CC]);
endmodule : pief_top

// ===== testbench/pief_evt_src.sv
// Event source model: a one-cycle request becomes a one-cycle event pulse
`timescale 1ns/100ps
module pief_evt_src (
	input  wire logic       clk_i,
	input  wire logic [5:0] fire_i,
	output logic      [5:0] evt_o
);
	// Registered so events leave just after an edge, like a real timer unit
	always_ff @(posedge clk_i) begin
		evt_o <= fire_i;
	end
endmodule : pief_evt_src

// ===== testbench/testbench.sv
// Self-checking bench for the peripheral interrupt flag block
`timescale 1ns/100ps
module testbench import pief_pkg::*;;
	localparam logic [7:0] EXP_BIT [6] = '{8'h01, 8'h02, 8'h04, 8'h04, 8'h08, 8'h40};
	logic              clk_i = 1'b0;
	logic              rst_i = 1'b1;
	logic              cyc = 1'b0;
	logic              stb = 1'b0;
	logic              we = 1'b0;
	logic [ADDR_W-1:0] adr = '0;
	logic [3:0]        sel = 4'h0;
	logic [DATA_W-1:0] wdat = '0;
	logic [DATA_W-1:0] rdat;
	logic [DATA_W-1:0] dat_o;
	logic [5:0]        fire = 6'h00;
	logic [5:0]        evt;
	logic              ack;
	logic              irq;
	logic [DATA_W-1:0] nc_wdat;
	logic [DATA_W-1:0] nc_dat;
	logic [DATA_W-1:0] nc_rdat;
	logic              nc_ack;
	logic              nc_irq;
	int                n_fail = 0;
	int                total_checks = 0;
	int                cyc_cnt = 0;

	always #4 clk_i = ~clk_i;

	pief_evt_src src_u (.clk_i(clk_i), .fire_i(fire), .evt_o(evt));
	pief_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .timer1_overflow_i(evt[0]), .timer2_match_i(evt[1]),
		.capture_evt_i(evt[2]), .compare_evt_i(evt[3]), .serial_done_i(evt[4]),
		.conv_done_i(evt[5]), .periph_irq_o(irq));

	// Converterless variant: software keeps bit 6 of flags and enables clear
	assign nc_wdat = wdat & ~(DATA_W'(adr == FLAGS_OFF || adr == ENABLES_OFF) << BIT_CV);
	pief_top #(.HAS_CONV(1'b0)) dut_nc_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(nc_wdat),
		.wb_dat_o(nc_dat), .wb_ack_o(nc_ack), .timer1_overflow_i(evt[0]),
		.timer2_match_i(evt[1]), .capture_evt_i(evt[2]), .compare_evt_i(evt[3]),
		.serial_done_i(evt[4]), .conv_done_i(evt[5]), .periph_irq_o(nc_irq));

	task automatic report_and_stop();
		if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Holds the request until ack is sampled; read data is taken at that edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		wdat <= {DAT_PAD, d};
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		rdat = dat_o;
		nc_rdat = nc_dat;
		chk("second instance ack", 32'h1, {31'h0, nc_ack});
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		chk(what, {DAT_PAD, exp}, rdat);
	endtask : rd_chk

	task automatic pulse(input logic [5:0] v);
		@(posedge clk_i);
		fire <= v;
		@(posedge clk_i);
		fire <= 6'h00;
		repeat (3) @(posedge clk_i);
	endtask : pulse

	// Request settles within two cycles of its cause
	task automatic irq_chk(input string what, input logic exp);
		repeat (3) @(posedge clk_i);
		chk(what, {31'h0, exp}, {31'h0, irq});
	endtask : irq_chk

	task automatic t_reset();
		rd_chk("flags at reset", FLAGS_OFF, REG_RESET);
		rd_chk("enables at reset", ENABLES_OFF, REG_RESET);
		chk("irq at reset", 32'h0, {31'h0, irq});
	endtask : t_reset

	task automatic t_rw();
		bus(1'b1, ENABLES_OFF, 8'hFF);
		rd_chk("enables all ones", ENABLES_OFF, IMPL_MASK);
		bus(1'b1, FLAGS_OFF, 8'hFF);
		rd_chk("flags all ones", FLAGS_OFF, IMPL_MASK);
		bus(1'b1, ENABLES_OFF, 8'hB0);
		rd_chk("enables unimpl", ENABLES_OFF, 8'h00);
		bus(1'b1, FLAGS_OFF, 8'h00);
		rd_chk("flags cleared", FLAGS_OFF, 8'h00);
		bus(1'b1, 8'h0D, 8'hFF);
		rd_chk("unmapped", 8'h0D, 8'h00);
	endtask : t_rw

	task automatic t_events();
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, CTRL_OFF, (i == 2) ? 8'h01 : (i == 3) ? 8'h02 : 8'h00);
			pulse(6'(1 << i));
			repeat (4) @(posedge clk_i);
			rd_chk("flag set", FLAGS_OFF, EXP_BIT[i]);
			bus(1'b1, FLAGS_OFF, 8'h00);
			rd_chk("flag cleared", FLAGS_OFF, 8'h00);
		end
		bus(1'b1, CTRL_OFF, 8'h03);
		pulse(6'h0C);
		rd_chk("capcmp in pwm", FLAGS_OFF, 8'h00);
	endtask : t_events

	task automatic t_irq();
		bus(1'b1, FLAGS_OFF, 8'h00);
		bus(1'b1, ENABLES_OFF, 8'h03);
		bus(1'b1, CTRL_OFF, 8'h80);
		pulse(6'h01);
		irq_chk("irq without master", 1'b0);
		bus(1'b1, CTRL_OFF, 8'h40);
		irq_chk("irq without global", 1'b0);
		bus(1'b1, CTRL_OFF, 8'hC0);
		irq_chk("irq timer1", 1'b1);
		bus(1'b1, FLAGS_OFF, 8'h00);
		irq_chk("irq after clear", 1'b0);
		pulse(6'h02);
		irq_chk("irq timer2", 1'b1);
		rd_chk("pending", PEND_OFF, 8'h02);
		rd_chk("control", CTRL_OFF, 8'hC0);
		bus(1'b1, ENABLES_OFF, 8'h01);
		irq_chk("irq masked", 1'b0);
		pulse(6'h10);
		irq_chk("irq serial disabled", 1'b0);
	endtask : t_irq

	task automatic t_noconv();
		bus(1'b1, FLAGS_OFF, 8'h00);
		bus(1'b1, ENABLES_OFF, 8'hFF);
		rd_chk("enables all ones", ENABLES_OFF, IMPL_MASK);
		chk("no-conv enables", {DAT_PAD, NOCONV_MASK}, nc_rdat);
		pulse(6'h20);
		rd_chk("conv flag", FLAGS_OFF, 8'h40);
		chk("no-conv conv flag", {DAT_PAD, REG_RESET}, nc_rdat);
		irq_chk("irq conv", 1'b1);
		chk("no-conv irq", 32'h0, {31'h0, nc_irq});
	endtask : t_noconv

	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_rw();
		t_events();
		t_irq();
		t_noconv();
		report_and_stop();
	end

	always @(posedge clk_i) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 5000) begin
			n_fail++;
			report_and_stop();
		end
	end
endmodule : testbench
